// ### include/pcei_regs.vh
// register map, field positions, reset values and rule overview for the pin change block
//
// Overview of operation
// - each pin has own rise and fall detector
// - rise detection only when rise enable set
// - fall detection only when fall enable set
// - both enables set detect both edges
// - enabled edge sets sticky pin flag
// - interrupt when any flag and master enable
// - summary flag is OR of flags, read-only
// - writing zero clears a pin flag
// - edge during flag write keeps flag set
// - master enable lets edges wake core
// - flags updated before wake reaches core
// - rise enable bits 5..0, reset zero
// - fall enable bits 5..0, reset zero
// - flag bits 5..0, reset zero, hardware set
// - detection continues with master enable off
`ifndef PCEI_REGS_VH
`define PCEI_REGS_VH

`define PCEI_NPINS          6
`define PCEI_ADDR_W         12
`define PCEI_OFF_RISE_EN    12'h000
`define PCEI_OFF_FALL_EN    12'h004
`define PCEI_OFF_FLAGS      12'h008
`define PCEI_OFF_CONTROL    12'h00c
`define PCEI_PIN_MSB        5
`define PCEI_CTL_ENABLE_BIT 0
`define PCEI_CTL_SUMMARY_BIT 1
`define PCEI_RST_PINS       6'h00
`define PCEI_RST_ENABLE     1'h0

`endif

// ### hdl/pcei_sync.v
// two-stage pin synchroniser with previous-sample edge detection
`timescale 1ns/1ps
module pcei_sync
(
    // clock and reset
    input  wire       pclk,
    input  wire       presetn,
    // raw pins
    input  wire [5:0] pin_levels,
    // edge pulses, one cycle
    output reg  [5:0] rise_q,
    output reg  [5:0] fall_q
);
    reg  [5:0] meta_q;
    reg  [5:0] sync_q;
    reg  [5:0] prev_q;
    reg  [2:0] primed_q;

    // meta stage feeds only sync stage; edges come from sync vs prev
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_q   <= 6'h00;
            sync_q   <= 6'h00;
            prev_q   <= 6'h00;
            primed_q <= 3'h0;
            rise_q   <= 6'h00;
            fall_q   <= 6'h00;
        end
        else
        begin
            meta_q   <= pin_levels;
            sync_q   <= meta_q;
            prev_q   <= sync_q;
            // prev holds a real level only from the third edge on, so a pin
            // already high at reset is never taken for a rise
            primed_q <= {primed_q[1:0], 1'b1};
            rise_q   <= primed_q[2] ? (sync_q & ~prev_q) : 6'h00;
            fall_q   <= primed_q[2] ? (~sync_q & prev_q) : 6'h00;
        end
    end
endmodule

// ### hdl/pcei_top.v
// pin change edge interrupt block with apb register slave
//
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "pcei_regs.vh"
module pcei_top
(
    // clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata_q,
    output reg         pready_q,
    output reg         pslverr_q,
    // port pins and core power state
    input  wire [5:0]  port_pin_n,
    input  wire        core_sleeping,
    // requests to the core
    output reg         change_int_req_q,
    output reg         wake_req_q
);
    reg  [5:0] rising_edge_enable_q;
    reg  [5:0] falling_edge_enable_q;
    reg  [5:0] edge_detect_flags_q;
    reg  [5:0] edge_detect_flags_d;
    reg        change_int_enable_q;
    wire [5:0] rise_ev;
    wire [5:0] fall_ev;
    wire [5:0] hit;
    wire       change_int_summary;
    wire       access;
    wire       wr_commit;
    wire       sel_rise;
    wire       sel_fall;
    wire       sel_flags;
    wire       sel_ctl;

    function hit_addr;
        input [11:0] a;
        input [11:0] off;
        begin
            hit_addr = (a == off);
        end
    endfunction

    // per-pin detectors
    pcei_sync u_sync
    (
        .pclk    (pclk),
        .presetn (presetn),
        .pin_levels (port_pin_n),
        .rise_q  (rise_ev),
        .fall_q  (fall_ev)
    );

    // each direction gated by its own enable, both may be on
    assign hit = (rise_ev & rising_edge_enable_q) | (fall_ev & falling_edge_enable_q);
    assign change_int_summary = |edge_detect_flags_q;

    // decode; write lands at the edge where pready is seen high
    assign access    = psel & penable;
    assign wr_commit = access & pready_q & pwrite;
    assign sel_rise  = hit_addr(paddr, `PCEI_OFF_RISE_EN);
    assign sel_fall  = hit_addr(paddr, `PCEI_OFF_FALL_EN);
    assign sel_flags = hit_addr(paddr, `PCEI_OFF_FLAGS);
    assign sel_ctl   = hit_addr(paddr, `PCEI_OFF_CONTROL);

    // flag next value: write loads pwdata, hardware set is ORed last
    always @*
    begin
        edge_detect_flags_d = edge_detect_flags_q;
        if (wr_commit && sel_flags)
            edge_detect_flags_d = pwdata[`PCEI_PIN_MSB:0];
        edge_detect_flags_d = edge_detect_flags_d | hit;
    end

    // register file
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rising_edge_enable_q  <= `PCEI_RST_PINS;
            falling_edge_enable_q <= `PCEI_RST_PINS;
            edge_detect_flags_q   <= `PCEI_RST_PINS;
            change_int_enable_q   <= `PCEI_RST_ENABLE;
        end
        else
        begin
            if (wr_commit && sel_rise)
                rising_edge_enable_q <= pwdata[`PCEI_PIN_MSB:0];
            if (wr_commit && sel_fall)
                falling_edge_enable_q <= pwdata[`PCEI_PIN_MSB:0];
            if (wr_commit && sel_ctl)
                change_int_enable_q <= pwdata[`PCEI_CTL_ENABLE_BIT];
            edge_detect_flags_q <= edge_detect_flags_d;
        end
    end

    // apb answer: one wait state, data and error ready with pready
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_q  <= 32'h00000000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            pready_q  <= access & ~pready_q;
            pslverr_q <= access & ~pready_q & ~(sel_rise | sel_fall | sel_flags | sel_ctl);
            prdata_q  <= 32'h00000000;
            if (access && !pready_q && !pwrite)
            begin
                // unused upper bits read as zero
                if (sel_rise)
                    prdata_q <= {26'h0000000, rising_edge_enable_q};
                else if (sel_fall)
                    prdata_q <= {26'h0000000, falling_edge_enable_q};
                else if (sel_flags)
                    prdata_q <= {26'h0000000, edge_detect_flags_q};
                else if (sel_ctl)
                    prdata_q <= {30'h00000000, change_int_summary, change_int_enable_q};
            end
        end
    end

    // requests follow the stored flags, so flags lead wake by a cycle
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            change_int_req_q <= 1'b0;
            wake_req_q       <= 1'b0;
        end
        else
        begin
            change_int_req_q <= change_int_summary & change_int_enable_q;
            wake_req_q <= core_sleeping & change_int_summary & change_int_enable_q;
        end
    end
endmodule

// ### sim/pcei_assertions.sv
// assertions on the apb and request outputs of the pin change block
`timescale 1ns/1ps
`include "pcei_regs.vh"
module pcei_checker
(
    // clock and reset
    input wire        pclk,
    input wire        presetn,
    // apb request and answer
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire        pready_q,
    input wire [31:0] prdata_q,
    // core state and requests
    input wire        core_sleeping,
    input wire        change_int_req_q,
    input wire        wake_req_q
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // access phase, and a control write that drops the master enable
    wire acc = psel && penable;
    wire off = acc && pready_q && pwrite && paddr == `PCEI_OFF_CONTROL && !pwdata[0];
    one_wait_a: assert property (acc && !pready_q |=> pready_q) else $error("no ready");
    rdy_pulse_a: assert property (pready_q |=> !pready_q) else $error("ready held");
    rdy_cause_a: assert property (pready_q |-> $past(acc)) else $error("stray ready");
    idle_zero_a: assert property (!pready_q |-> prdata_q == 32'h0) else $error("stray data");
    hi_zero_a: assert property (prdata_q[31:6] == 26'h0) else $error("high bits");
    irq_off_a: assert property (off |-> ##2 !change_int_req_q) else $error("irq on");
    wake_why_a: assert property (
        wake_req_q |-> change_int_req_q && $past(core_sleeping)) else $error("stray wake");
    wake_rise_a: assert property (
        $rose(change_int_req_q) && $past(core_sleeping) |-> wake_req_q) else $error("no wake");
    cover property ($rose(wake_req_q));
    cover property ($rose(change_int_req_q));
    cover property (off);
endmodule
bind pcei_top pcei_checker chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pready_q(pready_q), .core_sleeping(core_sleeping), .paddr(paddr),
    .change_int_req_q(change_int_req_q), .wake_req_q(wake_req_q), .pwdata(pwdata),
    .prdata_q(prdata_q));

// ### sim/pcei_pins.sv
// far-side pin driver: pins take the wanted levels at a clock edge
`timescale 1ns/1ps
module pcei_pins
(
    // clock, wanted levels, pins
    input wire       pclk,
    input wire [5:0] want,
    output reg [5:0] port_pin_n = 6'h00
);
    // levels move on an edge only, so no glitch shorter than a cycle
    always @(posedge pclk) port_pin_n <= want;
endmodule

// ### sim/pin_change_edge_interrupt_tb_top.sv
// self-checking bench for the pin change block
`timescale 1ns/1ps
`include "pcei_regs.vh"
module pin_change_edge_interrupt_tb_top;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slp = 0;
    logic        rdy, err, irq, wake, e;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, rd, prd;
    logic [5:0]  want = 0, pins;
    int          num_errors = 0, total_checks = 0, n;
    // rise enable, fall enable, first level, second level, flags expected
    logic [5:0]  rows [5][5] = '{'{6'h3f, 0, 0, 6'h3f, 6'h3f}, '{6'h3f, 0, 6'h3f, 0, 0},
        '{0, 6'h3f, 6'h3f, 0, 6'h3f}, '{0, 6'h15, 0, 6'h3f, 0}, '{6'h21, 6'h21, 1, 6'h20, 6'h21}};
    always #2.5 pclk = ~pclk;
    pcei_pins far (.pclk(pclk), .want(want), .port_pin_n(pins));
    pcei_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_q(prd), .pready_q(rdy),
        .pslverr_q(err), .port_pin_n(pins), .core_sleeping(slp), .change_int_req_q(irq),
        .wake_req_q(wake));
    task tally_and_finish;
        if (num_errors == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task chk(input string s, input logic [31:0] x, g);
        total_checks++;
        if (g !== x) begin num_errors++; $display("CHECK FAILED %s exp %h got %h", s, x, g); end
    endtask
    // one transfer, held until ready is sampled, then a released cycle
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk) penable <= 1;
        n = 0;
        do @(posedge pclk); while (rdy !== 1 && ++n < 20);
        rd = prd; e = err;
        if (n >= 20) begin num_errors++; tally_and_finish; end
        psel <= 0; penable <= 0;
        @(posedge pclk);
    endtask
    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        for (int a = 0; a < 16; a += 4) begin apb(0, a, 0); chk("reset", 0, rd); end
        // each row: settle, set enables, clear, move pins, read flags
        for (int i = 0; i < 5; i++)
        begin
            want <= rows[i][2];
            repeat (8) @(posedge pclk);
            apb(1, `PCEI_OFF_RISE_EN, rows[i][0]);
            apb(1, `PCEI_OFF_FALL_EN, rows[i][1]);
            apb(1, `PCEI_OFF_FLAGS, 0);
            want <= rows[i][3];
            repeat (8) @(posedge pclk);
            apb(0, `PCEI_OFF_FLAGS, 0);
            chk("flags", rows[i][4], rd);
            chk("irq off", 0, irq);
        end
        // masked clear of bit 0 only keeps the other flag
        apb(1, `PCEI_OFF_FLAGS, rd & ~32'h1);
        apb(0, `PCEI_OFF_FLAGS, 0);
        chk("clear", 6'h20, rd);
        apb(1, `PCEI_OFF_CONTROL, 1);
        repeat (2) @(posedge pclk);
        chk("irq", 1, irq);
        apb(0, `PCEI_OFF_CONTROL, 0);
        chk("summary", 3, rd);
        slp <= 1;
        repeat (2) @(posedge pclk);
        chk("wake", 1, wake);
        apb(1, `PCEI_OFF_FLAGS, 0);
        repeat (2) @(posedge pclk);
        chk("idle", 0, {irq, wake});
        // fresh edges while asleep: bounded wait for the wake
        want <= 6'h01;
        n = 0;
        while (wake !== 1 && n++ < 20) @(posedge pclk);
        if (wake !== 1) begin num_errors++; tally_and_finish; end
        chk("wake edge", 1, wake);
        apb(0, `PCEI_OFF_FLAGS, 0);
        chk("wake flags", 6'h21, rd);
        apb(1, `PCEI_OFF_CONTROL, 0);
        repeat (2) @(posedge pclk);
        chk("masked", 0, irq);
        // clear lands at the very edge a new fall on pin 0 is detected
        apb(1, `PCEI_OFF_FLAGS, 0);
        want <= 6'h00;
        repeat (2) @(posedge pclk);
        apb(1, `PCEI_OFF_FLAGS, 0);
        apb(0, `PCEI_OFF_FLAGS, 0);
        chk("set wins", 6'h01, rd);
        apb(1, 12'h010, '1);
        chk("bad addr", 1, e);
        // reset mid-run with requests up: all back to zero
        apb(1, `PCEI_OFF_CONTROL, 1);
        repeat (2) @(posedge pclk);
        chk("pre reset", 3, {irq, wake});
        presetn <= 0;
        repeat (3) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        chk("reset req", 0, {irq, wake});
        for (int a = 0; a < 16; a += 4) begin apb(0, a, 0); chk("rereset", 0, rd); end
        tally_and_finish;
    end
endmodule
